/* File: inc/eii_pkg.sv */
/*
 * Package for the external interrupt intake: register offsets, field
 * positions, reset values, vector offsets and state codes.
 * Assumes a 32-bit register port and a single processor clock.
 */
package eii_pkg;
    // ======================================================================
    // Register map (word offsets on the plain register port)
    localparam logic [3:0]  ADDR_CTRL      = 4'h0; // Enable bits
    localparam logic [3:0]  ADDR_STATUS    = 4'h1; // Sticky events, W1C
    localparam logic [3:0]  ADDR_MASK      = 4'h2; // Interrupt mask
    localparam logic [3:0]  ADDR_STATE     = 4'h3; // Live state
    localparam logic [3:0]  ADDR_NC_PC     = 4'h4; // Noncritical save pc
    localparam logic [3:0]  ADDR_NC_ST     = 4'h5; // Noncritical save state
    localparam logic [3:0]  ADDR_CR_PC     = 4'h6; // Critical save pc
    localparam logic [3:0]  ADDR_CR_ST     = 4'h7; // Critical save state
    localparam logic [3:0]  ADDR_RETURN    = 4'h8; // Write: return from handler
    // ======================================================================
    // Field positions
    localparam int          BIT_NC         = 0;
    localparam int          BIT_CR         = 1;
    localparam int          BIT_DBG        = 2;
    localparam logic [1:0]  CTRL_RESET     = 2'h0;
    localparam logic [2:0]  MASK_RESET     = 3'h0;
    // ======================================================================
    // Vector offsets
    localparam logic [31:0] VEC_CRIT       = 32'h0000_0100;
    localparam logic [31:0] VEC_NONCRIT    = 32'h0000_0200;
    localparam logic [31:0] DATA_ZERO      = 32'h0000_0000;
    // ======================================================================
    // Intake state, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_NC   = 3'b010,
        ST_CR   = 3'b100
    } eii_state_t;
endpackage

/* File: core/eii_sync.sv */
/*
 * Two-flop synchroniser for the request pins.
 * Assumes inputs arrive from logic outside the processor clock domain.
 */
module eii_sync (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    // Data
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_ff;
    logic q_ff;

    // ======================================================================
    // Synchroniser chain; first stage feeds only the second
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= 1'b0;
            q_ff    <= 1'b0;
        end else begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end
    assign q_o = q_ff;
endmodule // eii_sync

/* File: core/eii_save_pair.sv */
/*
 * One save/restore pair: program counter and state word.
 * Assumes a one-cycle save strobe from the intake logic.
 */
module eii_save_pair (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // Save port
    input  wire logic        save_i,
    input  wire logic [31:0] pc_i,
    input  wire logic [31:0] state_i,
    // Contents
    output logic [31:0]      pc_o,
    output logic [31:0]      state_o
);
    logic [31:0] pc_ff;
    logic [31:0] state_ff;

    // ======================================================================
    // Capture on save only, otherwise hold
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pc_ff    <= eii_pkg::DATA_ZERO;
            state_ff <= eii_pkg::DATA_ZERO;
        end else if (save_i) begin
            pc_ff    <= pc_i;
            state_ff <= state_i;
        end
    end
    assign pc_o    = pc_ff;
    assign state_o = state_ff;
endmodule // eii_save_pair

/* File: core/eii_intake.sv */
/*
 * External interrupt intake: samples critical and noncritical request
 * levels, gates them by enable bits, gives critical priority, saves return
 * state into the class's pair and issues the vector.
 * Assumes the collector holds requests until software clears them and ties
 * unused inputs low. Software reaches the registers on a plain port.
 */
module eii_intake (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // Request pins from the collector
    input  wire logic        crit_irq_request_in_i,
    input  wire logic        noncrit_irq_request_in_i,
    // Core context
    input  wire logic [31:0] cur_pc_i,
    input  wire logic [31:0] cur_state_i,
    input  wire logic        dbg_hold_i,
    // Register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    // Vector fetch
    output logic             fetch_o,
    output logic [31:0]      fetch_vec_o,
    // Enable state on the power management side
    output logic             noncrit_enable_bit_o,
    output logic             crit_enable_bit_o,
    // Interrupt
    output logic             irq_o
);
    logic                crit_req;
    logic                nc_req;
    logic [1:0]          ctrl_ff;
    logic [2:0]          status_ff;
    logic [2:0]          mask_ff;
    logic [31:0]         rdata_ff;
    logic                fetch_ff;
    logic [31:0]         vec_ff;
    logic                irq_ff;
    logic                ncen_ff;
    logic                cren_ff;
    eii_pkg::eii_state_t state_ff;
    eii_pkg::eii_state_t nxt_state;
    logic                take_cr;
    logic                take_nc;
    logic                ret_wr;
    logic [31:0]         nc_pc;
    logic [31:0]         nc_st;
    logic [31:0]         cr_pc;
    logic [31:0]         cr_st;

    // Register write decode shared by every writable register
    function automatic logic wr_hit(input logic we, input logic [3:0] a,
                                    input logic [3:0] target);
        return we && (a == target);
    endfunction

    // ======================================================================
    // Request sampling
    // two-flop sampling
    eii_sync u_sync_cr (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .d_i       (crit_irq_request_in_i),
        .q_o       (crit_req)
    );
    eii_sync u_sync_nc (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .d_i       (noncrit_irq_request_in_i),
        .q_o       (nc_req)
    );

    // ======================================================================
    // Take decision
    // critical enable gate; critical first
    assign take_cr = crit_req && ctrl_ff[eii_pkg::BIT_CR] && !dbg_hold_i
                     && (state_ff != eii_pkg::ST_CR);
    // noncritical enable gate; pending until enabled
    assign take_nc = nc_req && ctrl_ff[eii_pkg::BIT_NC] && !take_cr
                     && (state_ff == eii_pkg::ST_IDLE);
    assign ret_wr  = wr_hit(wr_i, addr_i, eii_pkg::ADDR_RETURN);

    // Next handler state; return from critical resumes noncritical if the written word has BIT_NC set
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            eii_pkg::ST_IDLE: begin
                if (take_cr) begin
                    nxt_state = eii_pkg::ST_CR;
                end else if (take_nc) begin
                    nxt_state = eii_pkg::ST_NC;
                end
            end
            eii_pkg::ST_NC: begin
                if (take_cr) begin
                    nxt_state = eii_pkg::ST_CR;
                end else if (ret_wr) begin
                    nxt_state = eii_pkg::ST_IDLE;
                end
            end
            eii_pkg::ST_CR: begin
                if (ret_wr) begin
                    nxt_state = wdata_i[eii_pkg::BIT_NC] ? eii_pkg::ST_NC
                                                         : eii_pkg::ST_IDLE;
                end
            end
            default: nxt_state = eii_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= eii_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ======================================================================
    // Save pairs
    // critical uses second pair, noncritical first
    eii_save_pair u_nc_pair (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .save_i    (take_nc),
        .pc_i      (cur_pc_i),
        .state_i   (cur_state_i),
        .pc_o      (nc_pc),
        .state_o   (nc_st)
    );
    eii_save_pair u_cr_pair (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .save_i    (take_cr),
        .pc_i      (cur_pc_i),
        .state_i   (cur_state_i),
        .pc_o      (cr_pc),
        .state_o   (cr_st)
    );

    // ======================================================================
    // Vector fetch
    // vector selection
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            fetch_ff <= 1'b0;
            vec_ff   <= eii_pkg::DATA_ZERO;
        end else begin
            fetch_ff <= take_cr || take_nc;
            if (take_cr) begin
                vec_ff <= eii_pkg::VEC_CRIT;
            end else if (take_nc) begin
                vec_ff <= eii_pkg::VEC_NONCRIT;
            end
        end
    end

    // ======================================================================
    // Enable bits, software writable
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_ff <= eii_pkg::CTRL_RESET;
        end else if (wr_hit(wr_i, addr_i, eii_pkg::ADDR_CTRL)) begin
            ctrl_ff <= wdata_i[1:0];
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ncen_ff <= 1'b0;
            cren_ff <= 1'b0;
        end else begin
            ncen_ff <= ctrl_ff[eii_pkg::BIT_NC];
            cren_ff <= ctrl_ff[eii_pkg::BIT_CR];
        end
    end

    // ======================================================================
    // Sticky status; a new event wins over a same-cycle clear
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            status_ff <= 3'h0;
        end else begin
            status_ff <= (status_ff
                          & ~(wr_hit(wr_i, addr_i, eii_pkg::ADDR_STATUS)
                              ? wdata_i[2:0] : 3'h0))
                         | {take_cr && (state_ff == eii_pkg::ST_NC),
                            take_cr, take_nc};
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mask_ff <= eii_pkg::MASK_RESET;
        end else if (wr_hit(wr_i, addr_i, eii_pkg::ADDR_MASK)) begin
            mask_ff <= wdata_i[2:0];
        end
    end

    // Level interrupt while any unmasked status bit stands
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // ======================================================================
    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_ff <= eii_pkg::DATA_ZERO;
        end else if (rd_i) begin
            unique case (addr_i)
                eii_pkg::ADDR_CTRL:   rdata_ff <= {30'h0, ctrl_ff};
                eii_pkg::ADDR_STATUS: rdata_ff <= {29'h0, status_ff};
                eii_pkg::ADDR_MASK:   rdata_ff <= {29'h0, mask_ff};
                eii_pkg::ADDR_STATE:  rdata_ff <= {25'h0, state_ff, 2'h0,
                                                   crit_req, nc_req};
                eii_pkg::ADDR_NC_PC:  rdata_ff <= nc_pc;
                eii_pkg::ADDR_NC_ST:  rdata_ff <= nc_st;
                eii_pkg::ADDR_CR_PC:  rdata_ff <= cr_pc;
                eii_pkg::ADDR_CR_ST:  rdata_ff <= cr_st;
                default:              rdata_ff <= eii_pkg::DATA_ZERO;
            endcase
        end else begin
            rdata_ff <= eii_pkg::DATA_ZERO;
        end
    end

    assign rdata_o              = rdata_ff;
    assign fetch_o              = fetch_ff;
    assign fetch_vec_o          = vec_ff;
    assign noncrit_enable_bit_o = ncen_ff;
    assign crit_enable_bit_o    = cren_ff;
    assign irq_o                = irq_ff;

    // ======================================================================
    // Checks
    sequence s_cr_take;
        take_cr;
    endsequence

    property p_crit_vec;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_cr_take |=> fetch_o && (fetch_vec_o == eii_pkg::VEC_CRIT);
    endproperty
    a_crit_vec: assert property (p_crit_vec) else $error("critical vector wrong");

    property p_nc_vec;
        @(posedge clk_sys_i) disable iff (rst_i)
        take_nc |=> fetch_o && (fetch_vec_o == eii_pkg::VEC_NONCRIT);
    endproperty
    a_nc_vec: assert property (p_nc_vec) else $error("noncritical vector wrong");

    property p_prio;
        @(posedge clk_sys_i) disable iff (rst_i)
        (crit_req && nc_req && ctrl_ff == 2'h3 && !dbg_hold_i
         && state_ff == eii_pkg::ST_IDLE) |-> take_cr && !take_nc;
    endproperty
    a_prio: assert property (p_prio) else $error("critical not first");

    property p_cr_pair;
        @(posedge clk_sys_i) disable iff (rst_i)
        take_cr |=> cr_pc == $past(cur_pc_i) && cr_st == $past(cur_state_i);
    endproperty
    a_cr_pair: assert property (p_cr_pair) else $error("critical pair not saved");

    property p_preempt;
        @(posedge clk_sys_i) disable iff (rst_i)
        (take_cr && state_ff == eii_pkg::ST_NC) |=> $stable(nc_pc) && $stable(nc_st);
    endproperty
    a_preempt: assert property (p_preempt) else $error("noncritical pair clobbered");

    property p_nc_gate;
        @(posedge clk_sys_i) disable iff (rst_i)
        !ctrl_ff[eii_pkg::BIT_NC] |-> !take_nc;
    endproperty
    a_nc_gate: assert property (p_nc_gate) else $error("noncritical taken while off");

    property p_cr_gate;
        @(posedge clk_sys_i) disable iff (rst_i)
        !ctrl_ff[eii_pkg::BIT_CR] |=> !($past(take_cr)) ##0 !fetch_o || $past(take_nc);
    endproperty
    a_cr_gate: assert property (p_cr_gate) else $error("critical taken while off");

    property p_en_out;
        @(posedge clk_sys_i) disable iff (rst_i)
        ##1 crit_enable_bit_o == $past(ctrl_ff[eii_pkg::BIT_CR])
            && noncrit_enable_bit_o == $past(ctrl_ff[eii_pkg::BIT_NC]);
    endproperty
    a_en_out: assert property (p_en_out) else $error("enable outputs stale");

    property p_pending;
        @(posedge clk_sys_i) disable iff (rst_i)
        (nc_req && !ctrl_ff[eii_pkg::BIT_NC] && state_ff == eii_pkg::ST_IDLE
         && !crit_req) ##1 (nc_req && ctrl_ff[eii_pkg::BIT_NC] && !crit_req)
        |-> take_nc;
    endproperty
    a_pending: assert property (p_pending) else $error("pending request lost");

    property p_sample;
        @(posedge clk_sys_i) disable iff (rst_i)
        crit_irq_request_in_i ##1 crit_irq_request_in_i |=> crit_req;
    endproperty
    a_sample: assert property (p_sample) else $error("request not sampled");

    property p_dbg_hold;
        @(posedge clk_sys_i) disable iff (rst_i)
        dbg_hold_i |=> !(fetch_o && fetch_vec_o == eii_pkg::VEC_CRIT);
    endproperty
    a_dbg_hold: assert property (p_dbg_hold) else $error("critical taken under debug hold");

    property p_irq_level;
        @(posedge clk_sys_i) disable iff (rst_i)
        |(status_ff & mask_ff) |=> irq_o;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level missing");
endmodule // eii_intake

/* File: sim/eii_collector_model.sv */
/*
 * Behavioural model of the external interrupt collector in fabric logic.
 * Assumes peripheral sources arrive as one-cycle pulses and that the
 * handler's write to the collector's clear register arrives as a pulse.
 */
module eii_collector_model (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    // Peripheral sources, one pulse per event
    input  wire logic [1:0] crit_src_i,
    input  wire logic [1:0] nc_src_i,
    // Handler writes to the collector clear register
    input  wire logic       clr_crit_i,
    input  wire logic       clr_nc_i,
    // Request lines toward the intake
    output logic            crit_irq_request_in_o,
    output logic            noncrit_irq_request_in_o
);
    // ======================================================================
    // Request latches
    logic crit_ff;
    logic nc_ff;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            crit_ff <= 1'b0;
        end else if (|crit_src_i) begin
            crit_ff <= 1'b1; // A new event beats a clear in the same cycle
        end else if (clr_crit_i) begin
            crit_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            nc_ff <= 1'b0;
        end else if (|nc_src_i) begin
            nc_ff <= 1'b1;
        end else if (clr_nc_i) begin
            nc_ff <= 1'b0;
        end
    end

    // Registered so the lines never glitch toward the synchroniser
    assign crit_irq_request_in_o    = crit_ff;
    assign noncrit_irq_request_in_o = nc_ff;
endmodule // eii_collector_model

/* File: sim/tb_top.sv */
/*
 * Self-checking bench for the external interrupt intake with a collector.
 * Assumes one 250 MHz clock and a register port with one-cycle strobes.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // Signals
    logic        clk_sys_i = 1'b0;
    logic        rst_i, crit_req, nc_req, dbg_hold_i, wr_i, rd_i;
    logic [31:0] cur_pc_i, cur_state_i, wdata_i, rdata_o, fetch_vec_o;
    logic [3:0]  addr_i;
    logic        fetch_o, nc_en, cr_en, irq_o, clr_crit, clr_nc;
    logic [1:0]  crit_src, nc_src;
    int          n_errors = 0;
    int          checked = 0;

    // Half period of 2 ns gives 250 MHz
    always #2 clk_sys_i = ~clk_sys_i;

    eii_collector_model coll (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .crit_src_i(crit_src),
        .nc_src_i(nc_src), .clr_crit_i(clr_crit), .clr_nc_i(clr_nc),
        .crit_irq_request_in_o(crit_req), .noncrit_irq_request_in_o(nc_req));

    eii_intake dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .crit_irq_request_in_i(crit_req),
        .noncrit_irq_request_in_i(nc_req), .cur_pc_i(cur_pc_i), .cur_state_i(cur_state_i),
        .dbg_hold_i(dbg_hold_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .fetch_o(fetch_o), .fetch_vec_o(fetch_vec_o),
        .noncrit_enable_bit_o(nc_en), .crit_enable_bit_o(cr_en), .irq_o(irq_o));

    // ======================================================================
    // Tasks
    task automatic print_verdict;
        $display("TB: errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    task automatic set_ctx(input logic [31:0] pc, input logic [31:0] st);
        @(posedge clk_sys_i);
        cur_pc_i    <= pc;
        cur_state_i <= st;
    endtask

    task automatic pulse(input logic crit, input logic [1:0] src);
        @(posedge clk_sys_i);
        if (crit) crit_src <= src;
        else nc_src <= src;
        @(posedge clk_sys_i);
        crit_src <= 2'h0;
        nc_src   <= 2'h0;
    endtask

    task automatic wait_fetch(input logic [31:0] vec);
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys_i);
            #1;
            if (fetch_o === 1'b1) break;
        end
        if (i == 20) begin
            chk({31'h0, fetch_o}, 32'h1);
            print_verdict();
        end else begin
            chk(fetch_vec_o, vec);
        end
    endtask

    task automatic no_fetch(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            #1;
            chk({31'h0, fetch_o}, 32'h0);
        end
    endtask

    // Handler clears the collector, lets the synchroniser drain, then returns
    task automatic finish_class(input logic crit, input logic [31:0] ret);
        @(posedge clk_sys_i);
        clr_crit <= crit;
        clr_nc   <= ~crit;
        @(posedge clk_sys_i);
        clr_crit <= 1'b0;
        clr_nc   <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        wr(eii_pkg::ADDR_RETURN, ret);
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        rst_i = 1'b1;
        {dbg_hold_i, wr_i, rd_i, clr_crit, clr_nc} = 5'h0;
        {cur_pc_i, cur_state_i, wdata_i} = 96'h0;
        {addr_i, crit_src, nc_src} = 8'h0;
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(eii_pkg::ADDR_CTRL, 32'h0);
        rd(eii_pkg::ADDR_STATUS, 32'h0);
        rd(4'hf, 32'h0);
        rd(eii_pkg::ADDR_STATE, 32'h0000_0010);
        chk({30'h0, cr_en, nc_en}, 32'h0);
        // Critical held pending while disabled, then taken
        set_ctx(32'h0000_1000, 32'h0000_0011);
        pulse(1'b1, 2'h1);
        no_fetch(10);
        // Debug hold keeps an enabled critical request waiting
        @(posedge clk_sys_i);
        dbg_hold_i <= 1'b1;
        wr(eii_pkg::ADDR_CTRL, 32'h2);
        no_fetch(4);
        @(posedge clk_sys_i);
        dbg_hold_i <= 1'b0;
        wait_fetch(eii_pkg::VEC_CRIT);
        chk({30'h0, cr_en, nc_en}, 32'h2);
        rd(eii_pkg::ADDR_CR_PC, 32'h0000_1000);
        rd(eii_pkg::ADDR_CR_ST, 32'h0000_0011);
        rd(eii_pkg::ADDR_STATUS, 32'h2);
        chk({31'h0, irq_o}, 32'h0);
        wr(eii_pkg::ADDR_MASK, 32'h2);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk({31'h0, irq_o}, 32'h1);
        wr(eii_pkg::ADDR_STATUS, 32'h2);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk({31'h0, irq_o}, 32'h0);
        finish_class(1'b1, 32'h0);
        // Noncritical blocked while only critical is enabled
        set_ctx(32'h0000_1800, 32'h0000_0022);
        pulse(1'b0, 2'h2);
        no_fetch(10);
        wr(eii_pkg::ADDR_CTRL, 32'h3);
        wait_fetch(eii_pkg::VEC_NONCRIT);
        rd(eii_pkg::ADDR_NC_PC, 32'h0000_1800);
        rd(eii_pkg::ADDR_NC_ST, 32'h0000_0022);
        // Critical preempts the running noncritical handler
        set_ctx(32'h0000_2000, 32'h0000_0033);
        pulse(1'b1, 2'h2);
        wait_fetch(eii_pkg::VEC_CRIT);
        rd(eii_pkg::ADDR_STATE, 32'h0000_0043);
        rd(eii_pkg::ADDR_NC_PC, 32'h0000_1800);
        rd(eii_pkg::ADDR_NC_ST, 32'h0000_0022);
        rd(eii_pkg::ADDR_CR_PC, 32'h0000_2000);
        rd(eii_pkg::ADDR_STATUS, 32'h7);
        finish_class(1'b1, 32'h1);
        no_fetch(6);
        finish_class(1'b0, 32'h0);
        // Both pending together: critical first, noncritical after
        wr(eii_pkg::ADDR_CTRL, 32'h0);
        pulse(1'b1, 2'h1);
        pulse(1'b0, 2'h1);
        no_fetch(4);
        wr(eii_pkg::ADDR_CTRL, 32'h3);
        wait_fetch(eii_pkg::VEC_CRIT);
        finish_class(1'b1, 32'h0);
        wait_fetch(eii_pkg::VEC_NONCRIT);
        finish_class(1'b0, 32'h0);
        print_verdict();
    end
endmodule // tb_top
